/* File: bar_model.sv */
// Purpose: Target side of the BAR request port
// Assumes: One request at a time, ack a one-cycle pulse
// Notes: Read data is a fixed function of the address
`timescale 1ns/10ps
module bar_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic bar_req,
   input wire logic [31:0] bar_addr,
   input wire logic slow,
   output logic bar_ack,
   output logic [31:0] bar_rdata
);
   logic [2:0] wait_q;
   // Data flips outside the ack cycle so a stale value never looks valid
   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
      begin
         wait_q <= 3'h0;
         bar_ack <= 1'b0;
         bar_rdata <= 32'h0;
      end
      else if (bar_req && !bar_ack && wait_q >= (slow ? 3'h4 : 3'h0))
      begin
         wait_q <= 3'h0;
         bar_ack <= 1'b1;
         bar_rdata <= bar_addr ^ 32'ha5a55a5a;
      end
      else
      begin
         wait_q <= (bar_req && !bar_ack) ? wait_q + 3'h1 : 3'h0;
         bar_ack <= 1'b0;
         bar_rdata <= ~bar_rdata;
      end
endmodule // bar_model

/* File: cfg_window.sv */
// Purpose: Configuration-space window forwarding into BAR regions
// Assumes: Driver keeps offset aligned and inside a described region
// Notes: Issues one BAR request and waits for its acknowledge
`timescale 1ns/10ps
module cfg_window (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [31:0] data_in,
   input wire logic [2:0] len,
   input wire logic [31:0] offset,
   input wire logic [7:0] bar,
   input wire logic bar_ack,
   input wire logic [31:0] bar_rdata,
   output logic bar_req,
   output logic bar_we,
   output logic [7:0] bar_sel,
   output logic [31:0] bar_addr,
   output logic [3:0] bar_be,
   output logic [31:0] bar_wdata,
   output logic [31:0] data_out,
   output logic busy
);
   legacy_regs_pkg::win_state_t st_q;
   legacy_regs_pkg::win_state_t st_d;
   logic [31:0] data_q;
   logic [3:0] be;
   // Only the first len bytes of the window take part
   assign be = (len == legacy_regs_pkg::win_len_1) ? 4'h1 :
               (len == legacy_regs_pkg::win_len_2) ? 4'h3 : 4'hf;
   always_comb
   begin
      st_d = st_q;
      case (st_q)
         legacy_regs_pkg::win_idle: if (data_wr) st_d = legacy_regs_pkg::win_wr;
            else if (data_rd) st_d = legacy_regs_pkg::win_rd;
         legacy_regs_pkg::win_wr, legacy_regs_pkg::win_rd: if (bar_ack) st_d = legacy_regs_pkg::win_done;
         legacy_regs_pkg::win_done: st_d = legacy_regs_pkg::win_idle;
         default: st_d = legacy_regs_pkg::win_idle;
      endcase
   end
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_q <= legacy_regs_pkg::win_idle;
         data_q <= 32'h0000_0000;
         bar_req <= 1'b0;
         bar_we <= 1'b0;
         bar_sel <= 8'h00;
         bar_addr <= 32'h0000_0000;
         bar_be <= 4'h0;
         bar_wdata <= 32'h0000_0000;
      end
      else
      begin
         st_q <= st_d;
         if (st_q == legacy_regs_pkg::win_idle && (data_wr || data_rd))
         begin
            bar_req <= 1'b1;
            bar_we <= data_wr;
            bar_sel <= bar;
            bar_addr <= offset;
            bar_be <= be;
            bar_wdata <= data_in & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
            if (data_wr)
               data_q <= data_in;
         end
         else if (bar_ack)
            bar_req <= 1'b0;
         if (st_q == legacy_regs_pkg::win_rd && bar_ack)
            data_q <= bar_rdata & {{8{bar_be[3]}}, {8{bar_be[2]}}, {8{bar_be[1]}}, {8{bar_be[0]}}};
      end
   end
   assign data_out = data_q;
   assign busy = (st_q != legacy_regs_pkg::win_idle);
endmodule // cfg_window

/* File: legacy_regs_chk.sv */
// Purpose: Port checks of the legacy register front end
// Assumes: One mclk domain, nrst low active
// Notes: Bound to the top module below
`timescale 1ns/10ps
module legacy_regs_chk (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic msix_enable,
   input wire logic nontransitional,
   input wire logic ring_event,
   input wire logic config_event,
   input wire logic win_data_wr,
   input wire logic win_data_rd,
   input wire logic [31:0] win_offset,
   input wire logic win_busy,
   input wire logic bar_req,
   input wire logic bar_ack,
   input wire logic bar_we,
   input wire logic [31:0] bar_addr,
   input wire logic [10:0] msix_table_size,
   input wire logic intx_pending,
   input wire logic msix_req,
   input wire logic [15:0] msix_vector,
   input wire logic doorbell_pulse,
   input wire logic [7:0] status_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_req_hold: assert property (bar_req && !bar_ack |=> bar_req && $stable(bar_addr))
      else $error("bar request dropped early");
   a_win_write: assert property (win_data_wr && !win_busy |=> bar_req && bar_we && bar_addr == $past(win_offset))
      else $error("window write not forwarded");
   a_win_read: assert property (win_data_rd && !win_busy |=> bar_req && !bar_we)
      else $error("window read not forwarded");
   a_cause_clear: assert property (io_rd && io_addr == 8'h13 && !msix_enable && !ring_event && !config_event
      |-> ##1 !intx_pending)
      else $error("cause read left interrupt pending");
   a_intx_msix: assert property (msix_enable && $past(msix_enable) && $past(msix_enable, 2) |-> !intx_pending)
      else $error("line interrupt while msix on");
   a_msix_off: assert property (!msix_enable && !$past(msix_enable) |-> !msix_req)
      else $error("message while msix off");
   a_status_zero: assert property (io_wr && io_addr == 8'h12 && io_wdata == 8'h00 |=> status_out == 8'h00)
      else $error("status not cleared");
   a_doorbell: assert property (io_wr && io_addr == 8'h11 && !nontransitional |=> doorbell_pulse)
      else $error("doorbell write lost");
   a_vec_range: assert property (msix_req |-> msix_vector <= {5'h00, msix_table_size})
      else $error("message on invalid vector");
   a_table_size: assert property (msix_table_size == 11'h007)
      else $error("table size wrong");
   c_msg: cover property (msix_req);
   c_win_rd: cover property (bar_ack && !bar_we);
   c_cause: cover property (io_rd && io_addr == 8'h13 && intx_pending);
endmodule // legacy_regs_chk
bind pci_transport_legacy_regs legacy_regs_chk chk_u (.mclk(mclk), .nrst(nrst), .io_wr(io_wr), .io_rd(io_rd),
   .io_addr(io_addr), .io_wdata(io_wdata), .msix_enable(msix_enable), .nontransitional(nontransitional),
   .ring_event(ring_event), .config_event(config_event), .win_data_wr(win_data_wr), .win_data_rd(win_data_rd),
   .win_offset(win_offset), .win_busy(win_busy), .bar_req(bar_req), .bar_ack(bar_ack), .bar_we(bar_we),
   .bar_addr(bar_addr), .msix_table_size(msix_table_size), .intx_pending(intx_pending), .msix_req(msix_req),
   .msix_vector(msix_vector), .doorbell_pulse(doorbell_pulse), .status_out(status_out));

/* File: legacy_regs_pkg.sv */
// Purpose: Shared constants for the legacy transport register front end
// Assumes: Byte-wide little-endian register access, 50 MHz mclk
// Notes: Offsets are byte offsets in the legacy I/O header
package legacy_regs_pkg;
   localparam logic [7:0] off_offered_features = 8'h00;
   localparam logic [7:0] off_accepted_features = 8'h04;
   localparam logic [7:0] off_ring_base_page = 8'h08;
   localparam logic [7:0] off_ring_depth = 8'h0c;
   localparam logic [7:0] off_ring_index_select = 8'h0e;
   localparam logic [7:0] off_ring_doorbell = 8'h10;
   localparam logic [7:0] off_device_status = 8'h12;
   localparam logic [7:0] off_interrupt_cause = 8'h13;
   localparam logic [7:0] off_config_event_vector = 8'h14;
   localparam logic [7:0] off_ring_event_vector = 8'h16;
   localparam logic [7:0] dev_cfg_base_plain = 8'h14;
   localparam logic [7:0] dev_cfg_base_msix = 8'h18;
   localparam logic [15:0] no_vector = 16'hffff;
   localparam logic [15:0] max_table_entry = 16'h07ff;
   localparam int num_rings = 4;
   localparam int dev_cfg_bytes = 16;
   localparam logic [31:0] offered_features_rst = 32'h0000_0000;
   localparam logic [15:0] ring_depth_rst = 16'h0100;
   localparam logic [10:0] table_size_rst = 11'h007;
   localparam int cause_ring_bit = 0;
   localparam int cause_config_bit = 1;
   // Window access lengths accepted from the driver
   localparam logic [2:0] win_len_1 = 3'h1;
   localparam logic [2:0] win_len_2 = 3'h2;
   localparam logic [2:0] win_len_4 = 3'h4;
   typedef enum logic [1:0] {
      win_idle = 2'b00,
      win_wr = 2'b01,
      win_rd = 2'b10,
      win_done = 2'b11
   } win_state_t;
endpackage

/* File: pci_transport_legacy_regs.sv */
// Purpose: Legacy I/O header, config window and vector maps of a transport
// Assumes: Byte-wide I/O port on BAR0, one-cycle read and write strobes
// Notes: Device config bytes are a plain byte array here
`timescale 1ns/10ps
module pci_transport_legacy_regs (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic msix_enable,
   input wire logic nontransitional,
   input wire logic ring_event,
   input wire logic config_event,
   input wire logic win_data_wr,
   input wire logic win_data_rd,
   input wire logic [31:0] win_data_in,
   input wire logic [2:0] win_len,
   input wire logic [31:0] win_offset,
   input wire logic [7:0] win_bar,
   input wire logic bar_ack,
   input wire logic [31:0] bar_rdata,
   output logic [7:0] io_rdata,
   output logic [10:0] msix_table_size,
   output logic intx_pending,
   output logic msix_req,
   output logic [15:0] msix_vector,
   output logic [31:0] accepted_features,
   output logic [31:0] ring_base,
   output logic [15:0] ring_select,
   output logic doorbell_pulse,
   output logic [15:0] doorbell_index,
   output logic [7:0] status_out,
   output logic bar_req,
   output logic bar_we,
   output logic [7:0] bar_sel,
   output logic [31:0] bar_addr,
   output logic [3:0] bar_be,
   output logic [31:0] bar_wdata,
   output logic [31:0] win_data_out,
   output logic win_busy
);
   logic [31:0] accepted_q;
   logic [31:0] ring_base_q;
   logic [15:0] select_q;
   logic [15:0] doorbell_q;
   logic [7:0] status_q;
   logic [7:0] cause_q;
   logic silenced_q;
   logic [7:0] rdata_q;
   logic db_pulse_q;
   logic irq_q;
   logic mreq_q;
   logic [15:0] mvec_q;
   logic [7:0] dev_cfg_q [legacy_regs_pkg::dev_cfg_bytes];
   logic [15:0] cfg_vec;
   logic [15:0] ring_vec [legacy_regs_pkg::num_rings];
   logic soft_reset;
   logic [7:0] cfg_base;
   logic [7:0] cfg_rel;
   logic in_cfg;
   logic hit_vec;
   logic wr_en;
   logic rd_cause;
   logic [15:0] sel_vec;
   logic [1:0] sel_idx;
   logic sel_valid;
   logic [7:0] hdr_byte;
   logic [7:0] cause_d;
   logic rwin_busy;

   // Silenced device answers zero and drops writes
   assign wr_en = io_wr && !silenced_q;
   assign soft_reset = wr_en && io_addr == legacy_regs_pkg::off_device_status && io_wdata == 8'h00;
   assign cfg_base = msix_enable ? legacy_regs_pkg::dev_cfg_base_msix
                                 : legacy_regs_pkg::dev_cfg_base_plain;
   assign cfg_rel = io_addr - cfg_base;
   assign in_cfg = io_addr >= cfg_base && cfg_rel < 8'(legacy_regs_pkg::dev_cfg_bytes);
   assign hit_vec = msix_enable && io_addr >= legacy_regs_pkg::off_config_event_vector
                    && io_addr < legacy_regs_pkg::dev_cfg_base_msix;
   assign rd_cause = io_rd && !silenced_q && io_addr == legacy_regs_pkg::off_interrupt_cause;
   assign sel_idx = select_q[1:0];
   assign sel_valid = select_q < 16'(legacy_regs_pkg::num_rings);
   assign sel_vec = sel_valid ? ring_vec[sel_idx] : legacy_regs_pkg::no_vector;

   // High byte only stages; the low byte write commits, so half a value is never granted
   logic cfg_vec_wr;
   logic ring_vec_wr;
   logic [15:0] vec_wdata;
   logic [15:0] cur_vec;
   logic [7:0] vec_hi_q;
   assign cur_vec = io_addr[1] ? sel_vec : cfg_vec;
   assign vec_wdata = {vec_hi_q, io_wdata};
   assign cfg_vec_wr = wr_en && hit_vec && !io_addr[1] && !io_addr[0];
   assign ring_vec_wr = wr_en && hit_vec && io_addr[1] && !io_addr[0] && sel_valid;

   vector_map_slot u_cfg_slot (
      .mclk(mclk),
      .nrst(nrst),
      .clr(soft_reset),
      .wr(cfg_vec_wr),
      .wdata(vec_wdata),
      .table_size(legacy_regs_pkg::table_size_rst),
      .vec(cfg_vec)
   );

   genvar gi;
   generate
      for (gi = 0; gi < legacy_regs_pkg::num_rings; gi++)
      begin : g_ring
         vector_map_slot u_ring_slot (
            .mclk(mclk),
            .nrst(nrst),
            .clr(soft_reset),
            .wr(ring_vec_wr && sel_idx == 2'(gi)),
            .wdata(vec_wdata),
            .table_size(legacy_regs_pkg::table_size_rst),
            .vec(ring_vec[gi])
         );
      end
   endgenerate

   // Header bytes, little endian, fields in fixed order
   always_comb
   begin
      hdr_byte = 8'h00;
      case (io_addr)
         8'h00: hdr_byte = legacy_regs_pkg::offered_features_rst[7:0];
         8'h01: hdr_byte = legacy_regs_pkg::offered_features_rst[15:8];
         8'h02: hdr_byte = legacy_regs_pkg::offered_features_rst[23:16];
         8'h03: hdr_byte = legacy_regs_pkg::offered_features_rst[31:24];
         8'h04: hdr_byte = accepted_q[7:0];
         8'h05: hdr_byte = accepted_q[15:8];
         8'h06: hdr_byte = accepted_q[23:16];
         8'h07: hdr_byte = accepted_q[31:24];
         8'h08: hdr_byte = ring_base_q[7:0];
         8'h09: hdr_byte = ring_base_q[15:8];
         8'h0a: hdr_byte = ring_base_q[23:16];
         8'h0b: hdr_byte = ring_base_q[31:24];
         8'h0c: hdr_byte = sel_valid ? legacy_regs_pkg::ring_depth_rst[7:0] : 8'h00;
         8'h0d: hdr_byte = sel_valid ? legacy_regs_pkg::ring_depth_rst[15:8] : 8'h00;
         8'h0e: hdr_byte = select_q[7:0];
         8'h0f: hdr_byte = select_q[15:8];
         8'h10: hdr_byte = doorbell_q[7:0];
         8'h11: hdr_byte = doorbell_q[15:8];
         8'h12: hdr_byte = status_q;
         8'h13: hdr_byte = cause_q;
         default: hdr_byte = 8'h00;
      endcase
      if (hit_vec)
         hdr_byte = io_addr[0] ? cur_vec[15:8] : cur_vec[7:0];
      else if (in_cfg)
         hdr_byte = dev_cfg_q[cfg_rel[3:0]];
   end

   // Set wins over the read-clear so no event is lost
   always_comb
   begin
      cause_d = rd_cause ? 8'h00 : cause_q;
      if (!msix_enable && ring_event)
         cause_d[legacy_regs_pkg::cause_ring_bit] = 1'b1;
      if (!msix_enable && config_event)
         cause_d[legacy_regs_pkg::cause_config_bit] = 1'b1;
      if (soft_reset)
         cause_d = 8'h00;
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         accepted_q <= 32'h0000_0000;
         ring_base_q <= 32'h0000_0000;
         select_q <= 16'h0000;
         doorbell_q <= 16'h0000;
         status_q <= 8'h00;
         silenced_q <= 1'b0;
         db_pulse_q <= 1'b0;
         vec_hi_q <= 8'h00;
      end
      else
      begin
         db_pulse_q <= wr_en && io_addr == legacy_regs_pkg::off_ring_doorbell + 8'h01;
         if (wr_en && hit_vec && io_addr[0])
            vec_hi_q <= io_wdata;
         if (soft_reset)
         begin
            accepted_q <= 32'h0000_0000;
            ring_base_q <= 32'h0000_0000;
            select_q <= 16'h0000;
            status_q <= 8'h00;
            silenced_q <= nontransitional;
         end
         else if (wr_en && !hit_vec)
         begin
            case (io_addr)
               8'h04: accepted_q[7:0] <= io_wdata;
               8'h05: accepted_q[15:8] <= io_wdata;
               8'h06: accepted_q[23:16] <= io_wdata;
               8'h07: accepted_q[31:24] <= io_wdata;
               8'h08: ring_base_q[7:0] <= io_wdata;
               8'h09: ring_base_q[15:8] <= io_wdata;
               8'h0a: ring_base_q[23:16] <= io_wdata;
               8'h0b: ring_base_q[31:24] <= io_wdata;
               8'h0e: select_q[7:0] <= io_wdata;
               8'h0f: select_q[15:8] <= io_wdata;
               8'h10: doorbell_q[7:0] <= io_wdata;
               8'h11: doorbell_q[15:8] <= io_wdata;
               8'h12: status_q <= io_wdata;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cause_q <= 8'h00;
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
         mreq_q <= 1'b0;
         mvec_q <= legacy_regs_pkg::no_vector;
      end
      else
      begin
         cause_q <= cause_d;
         irq_q <= !msix_enable && (|cause_d);
         rdata_q <= silenced_q ? 8'h00 : hdr_byte;
         // MSI-X delivery only when the event is bound; ring event uses selected ring
         mreq_q <= msix_enable && ((config_event && cfg_vec != legacy_regs_pkg::no_vector)
                   || (ring_event && sel_vec != legacy_regs_pkg::no_vector));
         // An unbound config event must not hide a bound ring event
         if (msix_enable && config_event && cfg_vec != legacy_regs_pkg::no_vector)
            mvec_q <= cfg_vec;
         else if (msix_enable && ring_event)
            mvec_q <= sel_vec;
      end
   end

   // Device config bytes are writable storage standing in for the device type
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < legacy_regs_pkg::dev_cfg_bytes; i++)
            dev_cfg_q[i] <= 8'h00;
      end
      else if (wr_en && in_cfg && !hit_vec)
         dev_cfg_q[cfg_rel[3:0]] <= io_wdata;
   end

   cfg_window u_window (
      .mclk(mclk),
      .nrst(nrst),
      .data_wr(win_data_wr),
      .data_rd(win_data_rd),
      .data_in(win_data_in),
      .len(win_len),
      .offset(win_offset),
      .bar(win_bar),
      .bar_ack(bar_ack),
      .bar_rdata(bar_rdata),
      .bar_req(bar_req),
      .bar_we(bar_we),
      .bar_sel(bar_sel),
      .bar_addr(bar_addr),
      .bar_be(bar_be),
      .bar_wdata(bar_wdata),
      .data_out(win_data_out),
      .busy(rwin_busy)
   );
   assign win_busy = rwin_busy;

   assign io_rdata = rdata_q;
   assign msix_table_size = legacy_regs_pkg::table_size_rst;
   assign intx_pending = irq_q;
   assign msix_req = mreq_q;
   assign msix_vector = mvec_q;
   // Upper 32 feature bits have no storage, so they read unacknowledged
   assign accepted_features = accepted_q;
   assign ring_base = ring_base_q;
   assign ring_select = select_q;
   assign doorbell_pulse = db_pulse_q;
   assign doorbell_index = doorbell_q;
   assign status_out = status_q;
endmodule // pci_transport_legacy_regs

/* File: pci_transport_legacy_regs_bench.sv */
// Purpose: Self-checking bench of the legacy register front end
// Assumes: Inputs change on the falling edge
// Notes: Random bytes come from an 8-bit shift register
`timescale 1ns/10ps
module pci_transport_legacy_regs_bench;
   logic mclk, nrst, io_wr, io_rd, msix_enable, nontransitional, ring_event, config_event, slow;
   logic win_data_wr, win_data_rd, bar_ack, intx_pending, msix_req, doorbell_pulse, bar_req, bar_we, win_busy;
   logic [7:0] io_addr, io_wdata, win_bar, io_rdata, bar_sel, status_out, b, seed;
   logic [31:0] win_data_in, win_offset, bar_rdata, accepted_features, ring_base, bar_addr, bar_wdata, win_data_out, w;
   logic [2:0] win_len;
   logic [10:0] msix_table_size;
   logic [15:0] msix_vector, ring_select, doorbell_index, v;
   logic [3:0] bar_be;
   logic [15:0] vt [6] = '{16'h0000, 16'h0007, 16'h0008, 16'h07ff, 16'h0800, 16'hffff};
   int n_fail, num_checks, cyc;
   pci_transport_legacy_regs dut_u (.mclk(mclk), .nrst(nrst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
      .io_wdata(io_wdata), .msix_enable(msix_enable), .nontransitional(nontransitional), .ring_event(ring_event),
      .config_event(config_event), .win_data_wr(win_data_wr), .win_data_rd(win_data_rd), .win_data_in(win_data_in),
      .win_len(win_len), .win_offset(win_offset), .win_bar(win_bar), .bar_ack(bar_ack), .bar_rdata(bar_rdata),
      .io_rdata(io_rdata), .msix_table_size(msix_table_size), .intx_pending(intx_pending), .msix_req(msix_req),
      .msix_vector(msix_vector), .accepted_features(accepted_features), .ring_base(ring_base),
      .ring_select(ring_select), .doorbell_pulse(doorbell_pulse), .doorbell_index(doorbell_index),
      .status_out(status_out), .bar_req(bar_req), .bar_we(bar_we), .bar_sel(bar_sel), .bar_addr(bar_addr),
      .bar_be(bar_be), .bar_wdata(bar_wdata), .win_data_out(win_data_out), .win_busy(win_busy));
   bar_model bar_u (.mclk(mclk), .nrst(nrst), .bar_req(bar_req), .bar_addr(bar_addr), .slow(slow),
      .bar_ack(bar_ack), .bar_rdata(bar_rdata));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [31:0] mask_of(input logic [2:0] l);
      return l == 3'h4 ? 32'hffffffff : l == 3'h2 ? 32'h0000ffff : 32'h000000ff;
   endfunction
   function automatic logic [15:0] vec_exp(input logic [15:0] x);
      return x <= 16'h0007 ? x : 16'hffff;
   endfunction
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_fail++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      {io_wr, io_addr, io_wdata} = {1'b1, a, d};
      @(negedge mclk);
      io_wr = 0;
   endtask
   task rdb(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      {io_rd, io_addr} = {1'b1, a};
      @(negedge mclk);
      io_rd = 0;
      chk("io_rdata", io_rdata, e);
   endtask
   // High byte first, the low byte write commits the binding
   task wrv(input logic [7:0] a, input logic [15:0] x);
      wr(a + 8'h01, x[15:8]);
      wr(a, x[7:0]);
   endtask
   task rdv(input logic [7:0] a, input logic [15:0] e);
      rdb(a, e[7:0]);
      rdb(a + 8'h01, e[15:8]);
   endtask
   task pulse(input logic c);
      @(negedge mclk);
      {ring_event, config_event} = {!c, c};
      @(negedge mclk);
      {ring_event, config_event} = 2'b00;
   endtask
   task wait_req(input logic [15:0] e);
      for (int i = 0; i < 8 && msix_req !== 1'b1; i++) @(negedge mclk);
      chk("msix_req", msix_req, 1);
      chk("msix_vector", msix_vector, e);
   endtask
   task win(input logic we, input logic [2:0] l, input logic [31:0] off);
      @(negedge mclk);
      seed = lfsr(seed);
      {win_len, win_offset, win_data_in, win_bar} = {l, off, {4{seed}}, 8'h01};
      {win_data_wr, win_data_rd} = {we, !we};
      @(negedge mclk);
      {win_data_wr, win_data_rd} = 2'b00;
      chk("bar_req", bar_req, 1);
      chk("bar_addr", bar_addr, off);
      chk("bar_sel", bar_sel, 8'h01);
      chk("bar_be", bar_be, l == 3'h4 ? 4'hf : l == 3'h2 ? 4'h3 : 4'h1);
      if (we) chk("bar_wdata", bar_wdata & mask_of(l), {4{seed}} & mask_of(l));
      for (int i = 0; i < 12 && win_busy !== 1'b0; i++) @(negedge mclk);
      if (!we) chk("win_data_out", win_data_out & mask_of(l), (off ^ 32'ha5a55a5a) & mask_of(l));
   endtask
   initial
   begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   // Ceiling well above the few hundred cycles the run needs
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         complete_run;
      end
   end
   initial
   begin
      {nrst, io_wr, io_rd, io_addr, io_wdata, msix_enable, nontransitional, ring_event, config_event} = 0;
      {win_data_wr, win_data_rd, win_data_in, win_len, win_offset, win_bar, slow} = 0;
      seed = 8'h4a;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      {nrst, msix_enable} = 2'b11;
      rdv(8'h14, 16'hffff);
      rdv(8'h16, 16'hffff);
      rdb(8'h13, 8'h00);
      rdb(8'h0d, 8'h01);
      wr(8'h00, 8'h5a);
      rdb(8'h00, 8'h00);
      chk("msix_table_size", msix_table_size, 11'h007);
      for (int i = 0; i < 12; i++)
      begin
         seed = lfsr(seed);
         v = i < 6 ? vt[i] : {12'h000, seed[3:0]};
         wrv(i % 2 ? 8'h16 : 8'h14, v);
         rdv(i % 2 ? 8'h16 : 8'h14, vec_exp(v));
      end
      for (int r = 0; r < 8; r++)
      begin
         wr(8'h0e, 8'(r % 4));
         wr(8'h0f, 8'h00);
         chk("ring_select", ring_select, r % 4);
         if (r < 4) wrv(8'h16, 16'(r + 1));
         else rdv(8'h16, 16'(r - 3));
      end
      wr(8'h0e, 8'h02);
      pulse(0);
      wait_req(16'h0003);
      wrv(8'h14, 16'h0005);
      pulse(1);
      wait_req(16'h0005);
      seed = lfsr(seed);
      b = seed;
      wr(8'h18, b);
      msix_enable = 0;
      rdb(8'h14, b);
      wr(8'h14, ~b);
      msix_enable = 1;
      rdb(8'h18, ~b);
      msix_enable = 0;
      for (int c = 0; c < 2; c++)
      begin
         pulse(c[0]);
         @(negedge mclk);
         chk("intx_pending", intx_pending, 1);
         rdb(8'h13, c ? 8'h02 : 8'h01);
         @(negedge mclk);
         chk("intx_pending", intx_pending, 0);
         rdb(8'h13, 8'h00);
      end
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr(seed);
         w[8 * (k % 4) +: 8] = seed;
         wr(8'h04 + 8'(k), seed);
         if (k == 3) chk("accepted_features", accepted_features, w);
         if (k == 7) chk("ring_base", ring_base, w);
      end
      wr(8'h10, 8'h02);
      wr(8'h11, 8'h00);
      chk("doorbell_pulse", doorbell_pulse, 1);
      chk("doorbell_index", doorbell_index, 16'h0002);
      wr(8'h12, 8'h0f);
      chk("status_out", status_out, 8'h0f);
      msix_enable = 1;
      wr(8'h12, 8'h00);
      rdb(8'h12, 8'h00);
      rdv(8'h14, 16'hffff);
      rdv(8'h16, 16'hffff);
      for (int k = 0; k < 12; k++)
      begin
         seed = lfsr(seed);
         slow = seed[0];
         win(k % 2, k % 6 < 2 ? 3'h1 : k % 6 < 4 ? 3'h2 : 3'h4, {22'h0, seed, 2'b00});
      end
      nontransitional = 1;
      wr(8'h12, 8'h00);
      rdb(8'h0d, 8'h00);
      wr(8'h0e, 8'h03);
      chk("ring_select", ring_select, 0);
      rdb(8'h0e, 8'h00);
      nontransitional = 0;
      nrst = 0;
      @(negedge mclk);
      nrst = 1;
      rdb(8'h0d, 8'h01);
      complete_run;
   end
endmodule // pci_transport_legacy_regs_bench

/* File: vector_map_slot.sv */
// Purpose: One event to vector binding with grant check
// Assumes: Table size in standard encoding (entries minus one)
// Notes: Refused bindings read back as the unmapped code
`timescale 1ns/10ps
module vector_map_slot (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic wr,
   input wire logic [15:0] wdata,
   input wire logic [10:0] table_size,
   output logic [15:0] vec
);
   logic [15:0] vec_q;
   logic [15:0] vec_d;
   logic grantable;
   assign grantable = (wdata <= legacy_regs_pkg::max_table_entry) && (wdata[10:0] <= table_size);
   assign vec_d = clr ? legacy_regs_pkg::no_vector :
                  wr ? (grantable ? wdata : legacy_regs_pkg::no_vector) : vec_q;
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         vec_q <= legacy_regs_pkg::no_vector;
      else
         vec_q <= vec_d;
   end
   assign vec = vec_q;
endmodule // vector_map_slot
